// ===== bench/dac_host_model.sv
`timescale 1ns/100ps
// Host side of the link; sclk idles high and runs only inside frames
module dac_host_model (
  output logic sclk,
  output logic frame_select_n,
  output logic sdin,
  input wire sdo
);
  logic [23:0] rd;
  initial begin
    sclk = 1'b1;
    frame_select_n = 1'b1;
    sdin = 1'b0;
  end
  // Top n bits of w go out MSB first; sdo is taken on each fall
  task automatic xfer(input logic [31:0] w, input int n);
    #1 frame_select_n = 1'b0;
    #125;
    for (int i = 0; i < n; i++) begin
      sdin = w[31-i];
      #62.5 sclk = 1'b0;
      rd = {rd[22:0], sdo};
      #62.5 sclk = 1'b1;
    end
    #125 frame_select_n = 1'b1;
    sdin = ~sdin; // Released line must not keep a stale level
  endtask
endmodule // dac_host_model

// ===== bench/dac_pin_ctrl_monitor.sv
`timescale 1ns/100ps
module dac_pin_ctrl_monitor #(
  parameter CHANNELS = 4,
  parameter DATA_W = 16,
  parameter IDLE_TIMEOUT_CYC = 200
) (
  input wire ref_clk,
  input wire rst_n,
  input wire sclk,
  input wire frame_select_n,
  input wire sdin,
  input wire load_strobe_n,
  input wire clear_in,
  input wire open_circuit_det,
  input wire short_circuit_det,
  input wire overtemp_det,
  input wire sdo,
  input wire [CHANNELS*DATA_W-1:0] out_code,
  input wire fault_n_o,
  input wire fault_n_oe,
  input wire idle_timeout_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  int idle_ff;
  int quiet_ff;
  logic [2:0] lnk_ff;
  logic [2:0] upd_ff;
  ////////////////////
  // Cycles since link pins or update pins last moved; saturate to stay small
  always @(posedge ref_clk) begin
    lnk_ff <= {sclk, frame_select_n, sdin};
    upd_ff <= {frame_select_n, load_strobe_n, clear_in};
    if (!rst_n || lnk_ff != {sclk, frame_select_n, sdin}) idle_ff <= 0;
    else if (idle_ff < IDLE_TIMEOUT_CYC + 50) idle_ff <= idle_ff + 1;
    if (!rst_n || upd_ff != {frame_select_n, load_strobe_n, clear_in}) quiet_ff <= 0;
    else if (quiet_ff < 50) quiet_ff <= quiet_ff + 1;
  end
  ////////////////////
  reset_values_a: assert property ($rose(rst_n) |-> out_code == '0 && !fault_n_oe
    && !idle_timeout_flag && !sdo) else $error("outputs not at reset values");
  fault_pin_a: assert property (fault_n_o == 1'b0) else $error("fault data not low");
  fault_raise_a: assert property ($rose(open_circuit_det | short_circuit_det
    | overtemp_det) |-> ##[1:8] fault_n_oe) else $error("fault not raised");
  fault_hold_a: assert property (overtemp_det [*8] |-> fault_n_oe)
    else $error("fault dropped while hot");
  out_quiet_a: assert property (quiet_ff > 10 |-> $stable(out_code))
    else $error("output moved without cause");
  clear_hold_a: assert property (clear_in [*8] ##1 clear_in |-> $stable(out_code))
    else $error("output written during clear");
  idle_raise_a: assert property (idle_ff > IDLE_TIMEOUT_CYC + 10 |-> idle_timeout_flag)
    else $error("idle flag late");
  idle_low_a: assert property (idle_ff > 8 && idle_ff < IDLE_TIMEOUT_CYC
    |-> !idle_timeout_flag) else $error("idle flag early");
  sdo_idle_a: assert property (frame_select_n [*8] |-> !sdo)
    else $error("sdo driven outside frame");
  cover property ($rose(idle_timeout_flag));
  cover property ($rose(clear_in));
  cover property ($rose(fault_n_oe));
endmodule // dac_pin_ctrl_monitor

bind dac_pin_ctrl dac_pin_ctrl_monitor #(.CHANNELS(CHANNELS), .DATA_W(DATA_W),
  .IDLE_TIMEOUT_CYC(IDLE_TIMEOUT_CYC)) dac_pin_ctrl_monitor_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .frame_select_n(frame_select_n),
  .sdin(sdin), .load_strobe_n(load_strobe_n), .clear_in(clear_in),
  .open_circuit_det(open_circuit_det), .short_circuit_det(short_circuit_det),
  .overtemp_det(overtemp_det), .sdo(sdo), .out_code(out_code), .fault_n_o(fault_n_o),
  .fault_n_oe(fault_n_oe), .idle_timeout_flag(idle_timeout_flag));

// ===== bench/dac_pin_ctrl_tb.sv
`timescale 1ns/100ps
module dac_pin_ctrl_tb;
  localparam int IDLE = 200;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic load_strobe_n = 1'b0;
  logic clear_in = 1'b0;
  logic open_circuit_det = 1'b0;
  logic short_circuit_det = 1'b0;
  logic overtemp_det = 1'b0;
  wire sclk, frame_select_n, sdin, sdo, fault_n_o, fault_n_oe, idle_timeout_flag;
  wire [63:0] out_code;
  logic [15:0] exp_out [4];
  logic [15:0] exp_in [4];
  logic [15:0] d;
  logic [23:0] w;
  int fails;
  int num_checks;
  int n;
  // Reference clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  dac_host_model dac_host_model_inst (.sclk(sclk), .frame_select_n(frame_select_n),
    .sdin(sdin), .sdo(sdo));
  dac_pin_ctrl #(.IDLE_TIMEOUT_CYC(IDLE)) dac_pin_ctrl_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .sclk(sclk), .frame_select_n(frame_select_n), .sdin(sdin),
    .load_strobe_n(load_strobe_n), .clear_in(clear_in), .open_circuit_det(open_circuit_det),
    .short_circuit_det(short_circuit_det), .overtemp_det(overtemp_det), .sdo(sdo),
    .out_code(out_code), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
    .idle_timeout_flag(idle_timeout_flag));
  ////////////////////
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [63:0] pack_out();
    for (int i = 0; i < 4; i++) pack_out[16*i +: 16] = exp_out[i];
  endfunction
  function automatic logic [23:0] word(logic r, logic [1:0] ch, logic [1:0] k, logic [15:0] v);
    return {r, ch, k, 3'h0, v};
  endfunction
  // Check byte is worked out here, apart from the design
  function automatic logic [7:0] crc8(input logic [23:0] x);
    crc8 = 8'h00;
    for (int i = 23; i >= 0; i--) crc8 = {crc8[6:0], 1'b0} ^ ((crc8[7] ^ x[i]) ? 8'h07 : 8'h00);
  endfunction
  // One frame, then time for the sync latency to pass
  task automatic wr(input logic [23:0] x, input logic chk);
    @(negedge ref_clk);
    if (chk) dac_host_model_inst.xfer({x, crc8(x)}, 32);
    else dac_host_model_inst.xfer({x, 8'h00}, 24);
    repeat (12) @(negedge ref_clk);
  endtask
  ////////////////////
  initial begin
    void'($urandom(31));
    for (int i = 0; i < 4; i++) exp_out[i] = 16'h0000;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    cmp("out_code", pack_out(), out_code);
    for (int c = 0; c < 4; c++) begin
      d = (c == 3) ? 16'hffff : 16'($urandom);
      wr(word(1'b0, 2'(c), 2'h0, d), c[0]);
      exp_in[c] = d;
      exp_out[c] = d;
      cmp("out_code", pack_out(), out_code);
    end
    $display("test immediate done");
    load_strobe_n = 1'b1;
    for (int c = 0; c < 4; c++) begin
      exp_in[c] = 16'($urandom);
      wr(word(1'b0, 2'(c), 2'h0, exp_in[c]), 1'b0);
      cmp("out_code", pack_out(), out_code);
    end
    @(negedge ref_clk) load_strobe_n = 1'b0;
    repeat (12) @(negedge ref_clk);
    for (int c = 0; c < 4; c++) exp_out[c] = exp_in[c];
    cmp("out_code", pack_out(), out_code);
    $display("test deferred done");
    d = 16'($urandom);
    wr(word(1'b0, 2'h0, 2'h1, d), 1'b0);
    wr(word(1'b0, 2'h0, 2'h2, 16'h0001), 1'b0);
    wr(word(1'b0, 2'h2, 2'h2, 16'h0001), 1'b1);
    @(negedge ref_clk) clear_in = 1'b1;
    repeat (12) @(negedge ref_clk);
    exp_out[0] = d;
    exp_out[2] = d;
    cmp("out_code", pack_out(), out_code);
    exp_in[1] = 16'($urandom);
    wr(word(1'b0, 2'h1, 2'h0, exp_in[1]), 1'b0);
    cmp("out_code", pack_out(), out_code);
    clear_in = 1'b0;
    wr(word(1'b1, 2'h1, 2'h0, 16'h0000), 1'b0);
    wr(word(1'b1, 2'h0, 2'h3, 16'h0000), 1'b0);
    cmp("readback", {40'h0, word(1'b1, 2'h1, 2'h0, exp_in[1])},
      {40'h0, dac_host_model_inst.rd});
    wr(word(1'b1, 2'h2, 2'h2, 16'h0000), 1'b0);
    cmp("readback", {40'h0, word(1'b1, 2'h0, 2'h3, exp_out[0])},
      {40'h0, dac_host_model_inst.rd});
    wr(word(1'b1, 2'h0, 2'h1, 16'h0000), 1'b0);
    cmp("readback", {40'h0, word(1'b1, 2'h2, 2'h2, 16'h0001)},
      {40'h0, dac_host_model_inst.rd});
    $display("test clear and readback done");
    for (int i = 0; i < 3; i++) begin
      {overtemp_det, short_circuit_det, open_circuit_det} = 3'h1 << i;
      repeat (12) @(negedge ref_clk);
      cmp("fault", 64'h1, {63'h0, fault_n_oe});
      {overtemp_det, short_circuit_det, open_circuit_det} = 3'h0;
      repeat (12) @(negedge ref_clk);
      cmp("fault", 64'h0, {63'h0, fault_n_oe});
    end
    w = word(1'b0, 2'h0, 2'h0, 16'h1234);
    dac_host_model_inst.xfer({w, ~crc8(w)}, 32);
    repeat (12) @(negedge ref_clk);
    cmp("fault", 64'h1, {63'h0, fault_n_oe});
    cmp("out_code", pack_out(), out_code);
    $display("test fault done");
    for (n = 0; n < IDLE + 50 && idle_timeout_flag !== 1'b1; n++) @(negedge ref_clk);
    cmp("idle", 64'h1, {63'h0, idle_timeout_flag});
    if (n >= IDLE + 50) final_report();
    wr(word(1'b0, 2'h3, 2'h0, exp_in[3]), 1'b0);
    cmp("idle", 64'h0, {63'h0, idle_timeout_flag});
    $display("test idle done");
    for (n = 0; n < IDLE + 50 && idle_timeout_flag !== 1'b1; n++) @(negedge ref_clk);
    cmp("idle", 64'h1, {63'h0, idle_timeout_flag});
    if (n >= IDLE + 50) final_report();
    rst_n = 1'b0;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    cmp("out_code", 64'h0, out_code);
    cmp("fault", 64'h0, {63'h0, fault_n_oe});
    cmp("idle", 64'h0, {63'h0, idle_timeout_flag});
    $display("test reset done");
    final_report();
  end
  // Hang guard
  initial begin
    #500000;
    fails++;
    final_report();
  end
endmodule // dac_pin_ctrl_tb

// ===== logic/dac_pin_ctrl.v
// Notes on behaviour
// - Load low: frame end writes addressed channel output directly.
// - Load high during write: only input register updates, output waits for load fall.
// - One load falling edge copies all input registers to outputs together.
// - Clear rising edge forces outputs to the programmed clear code.
// - Clear touches only channels with clear enable set.
// - While clear is high, output register writes are ignored.
// - Idle flag rises after timeout with no serial pin activity.
// - Fault pin pulled low on open, short, packet check error or overtemperature.
// - Active low hardware reset puts the device in reset state.
// - Readback shifts the serial register out on sdo with serial clock.
// - Frame select low frames data; bits taken on falling serial clock.
`timescale 1ns/100ps
`include "dac_pins_defs.vh"

module dac_pin_ctrl #(
  parameter CHANNELS = 4,
  parameter DATA_W = 16,
  parameter IDLE_TIMEOUT_CYC = `IDLE_TIMEOUT_CYC
) (
  input wire ref_clk,
  input wire rst_n,
  input wire sclk,
  input wire frame_select_n,
  input wire sdin,
  input wire load_strobe_n,
  input wire clear_in,
  input wire open_circuit_det,
  input wire short_circuit_det,
  input wire overtemp_det,
  output wire sdo,
  output wire [CHANNELS*DATA_W-1:0] out_code,
  output wire fault_n_o,
  output wire fault_n_oe,
  output wire idle_timeout_flag
);

  localparam NPINS = 8;
  localparam ST_IDLE = 2'b01;
  localparam ST_FRAME = 2'b10;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire [NPINS-1:0] pin_raw;
  wire [NPINS-1:0] pin_rst;
  wire [NPINS-1:0] pin_s;
  reg [NPINS-1:0] pin_q_ff;

  assign pin_raw = {overtemp_det, short_circuit_det, open_circuit_det, clear_in,
                    load_strobe_n, sdin, frame_select_n, sclk};
  // Idle levels: serial clock, frame select and load strobe high, everything else low
  assign pin_rst = 8'h0b;

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_sync
      pin_sync3 u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_in(pin_raw[gi]),
        .rst_val(pin_rst[gi]),
        .pin_out(pin_s[gi])
      );
    end
  endgenerate

  // Previous synchronised levels for edge detection
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_q_ff <= 8'h0b;
    end else begin
      pin_q_ff <= pin_s;
    end
  end

  wire sclk_fall = pin_q_ff[0] & ~pin_s[0];
  wire sclk_rise = ~pin_q_ff[0] & pin_s[0];
  wire frame_start = pin_q_ff[1] & ~pin_s[1];
  wire frame_end = ~pin_q_ff[1] & pin_s[1];
  wire sdin_s = pin_s[2];
  wire load_low = ~pin_s[3];
  wire load_fall = pin_q_ff[3] & ~pin_s[3];
  wire clear_s = pin_s[4];
  wire clear_rise = ~pin_q_ff[4] & pin_s[4];

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame receiver and readback shifter
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [`FRAME_CHK_BITS-1:0] rx_ff;
  reg [`BIT_CNT_W-1:0] bit_cnt_ff;
  reg [7:0] chk_ff;
  reg [`FRAME_BITS-1:0] tx_ff;
  reg rb_pend_ff;
  reg [1:0] rb_chan_ff;
  reg [1:0] rb_kind_ff;
  reg pec_err_ff;
  reg [DATA_W-1:0] clr_code_ff;
  reg [CHANNELS-1:0] clr_en_ff;
  reg [DATA_W-1:0] in_ff [0:CHANNELS-1];
  reg [DATA_W-1:0] out_ff [0:CHANNELS-1];
  reg [DATA_W-1:0] rb_data;

  wire in_frame = state_ff[1];
  wire len_plain = bit_cnt_ff == `FRAME_BITS;
  wire len_chk = bit_cnt_ff == `FRAME_CHK_BITS;
  wire chk_ok = rx_ff[7:0] == chk_ff;
  wire [`FRAME_BITS-1:0] word = len_chk ? rx_ff[`FRAME_CHK_BITS-1:8] : rx_ff[`FRAME_BITS-1:0];
  wire frame_good = frame_end & in_frame & (len_plain | (len_chk & chk_ok));
  wire frame_bad_chk = frame_end & in_frame & len_chk & ~chk_ok;
  wire wr_cmd = frame_good & ~word[`FLD_READ];
  wire rd_cmd = frame_good & word[`FLD_READ];
  wire [1:0] w_chan = word[`FLD_CHAN_HI:`FLD_CHAN_LO];
  wire [1:0] w_kind = word[`FLD_KIND_HI:`FLD_KIND_LO];
  wire [DATA_W-1:0] w_data = word[DATA_W-1:0];
  wire chk_fb = chk_ff[7] ^ sdin_s;

  // Frame state; a frame is bounded by frame select, not by bit count
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (frame_start) begin
          nxt_state = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (frame_end) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Readback source select
  always @* begin
    rb_data = in_ff[rb_chan_ff];
    if (rb_kind_ff == `KIND_CLR_CODE) begin
      rb_data = clr_code_ff;
    end else if (rb_kind_ff == `KIND_CLR_EN) begin
      rb_data = {{(DATA_W-1){1'b0}}, clr_en_ff[rb_chan_ff]};
    end else if (rb_kind_ff == `KIND_OUTPUT) begin
      rb_data = out_ff[rb_chan_ff];
    end
  end

  // Shift in on falling serial clock, running packet check over the first 24 bits
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      rx_ff <= 32'h00000000;
      bit_cnt_ff <= 6'h00;
      chk_ff <= `CHK_INIT;
    end else begin
      state_ff <= nxt_state;
      if (frame_start) begin
        bit_cnt_ff <= 6'h00;
        chk_ff <= `CHK_INIT;
      end else if (in_frame && sclk_fall) begin
        rx_ff <= {rx_ff[`FRAME_CHK_BITS-2:0], sdin_s};
        if (bit_cnt_ff != {`BIT_CNT_W{1'b1}}) begin
          bit_cnt_ff <= bit_cnt_ff + 6'h01;
        end
        if (bit_cnt_ff < `FRAME_BITS) begin
          chk_ff <= {chk_ff[6:0], 1'b0} ^ (chk_fb ? `CHK_POLY : 8'h00);
        end
      end
    end
  end

  // Readback: a read frame arms the next frame to shift out header and data
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_ff <= 24'h000000;
      rb_pend_ff <= 1'b0;
      rb_chan_ff <= 2'h0;
      rb_kind_ff <= 2'h0;
    end else begin
      if (rd_cmd) begin
        rb_pend_ff <= 1'b1;
        rb_chan_ff <= w_chan;
        rb_kind_ff <= w_kind;
      end else if (frame_start && rb_pend_ff) begin
        rb_pend_ff <= 1'b0;
        tx_ff <= {1'b1, rb_chan_ff, rb_kind_ff, 3'h0, rb_data};
      end else if (in_frame && sclk_rise) begin
        tx_ff <= {tx_ff[`FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  reg sdo_ff;

  // Driven only while framed; the register costs one cycle the host must allow for
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      sdo_ff <= 1'b0;
    end else begin
      sdo_ff <= tx_ff[`FRAME_BITS-1] & in_frame;
    end
  end

  assign sdo = sdo_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Channel registers, clear settings and output update
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      clr_code_ff <= `CODE_RESET;
      clr_en_ff <= {CHANNELS{1'b0}};
    end else if (wr_cmd && w_kind == `KIND_CLR_CODE) begin
      clr_code_ff <= w_data;
    end else if (wr_cmd && w_kind == `KIND_CLR_EN) begin
      clr_en_ff[w_chan] <= w_data[0];
    end
  end

  generate
    for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_chan
      wire hit = wr_cmd && (w_kind == `KIND_INPUT) && (w_chan == gi);
      wire [DATA_W-1:0] nxt_in = hit ? w_data : in_ff[gi];

      // Input register always takes a data write
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          in_ff[gi] <= `CODE_RESET;
        end else if (hit) begin
          in_ff[gi] <= w_data;
        end
      end

      // Clear edge outranks updates; clear level blocks them outright
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          out_ff[gi] <= `CODE_RESET;
        end else if (clear_rise && clr_en_ff[gi]) begin
          out_ff[gi] <= clr_code_ff;
        end else if (clear_s) begin
          out_ff[gi] <= out_ff[gi];
        end else if (load_fall) begin
          out_ff[gi] <= nxt_in;
        end else if (hit && load_low) begin
          out_ff[gi] <= w_data;
        end
      end

      assign out_code[gi*DATA_W +: DATA_W] = out_ff[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Idle timeout watch on the serial pins
  reg [31:0] idle_cnt_ff;
  reg idle_ff;
  wire pin_activity = |(pin_s[2:0] ^ pin_q_ff[2:0]);

  // Flag stays high until the next serial activity
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      idle_cnt_ff <= 32'h00000000;
      idle_ff <= 1'b0;
    end else if (pin_activity) begin
      idle_cnt_ff <= 32'h00000000;
      idle_ff <= 1'b0;
    end else if (idle_cnt_ff == IDLE_TIMEOUT_CYC - 1) begin
      idle_ff <= 1'b1;
    end else begin
      idle_cnt_ff <= idle_cnt_ff + 32'h00000001;
    end
  end

  assign idle_timeout_flag = idle_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Fault output; packet check error is sticky until reset
  reg fault_ff;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pec_err_ff <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      pec_err_ff <= pec_err_ff | frame_bad_chk;
      fault_ff <= pec_err_ff | frame_bad_chk | pin_s[5] | pin_s[6] | pin_s[7];
    end
  end

  // Open drain: only ever pulls low
  assign fault_n_o = 1'b0;
  assign fault_n_oe = fault_ff;

endmodule // dac_pin_ctrl

// ===== logic/dac_pins_defs.vh
`ifndef DAC_PINS_DEFS_VH
`define DAC_PINS_DEFS_VH

// Reference clock rate and idle timeout
`define CLK_MHZ 100
`define IDLE_TIMEOUT_US 1000
`define IDLE_TIMEOUT_CYC (`IDLE_TIMEOUT_US * `CLK_MHZ)

// Frame lengths in serial clock bits
`define FRAME_BITS 24
`define FRAME_CHK_BITS 32
`define BIT_CNT_W 6

// Field positions inside a 24-bit frame
`define FLD_READ 23
`define FLD_CHAN_HI 22
`define FLD_CHAN_LO 21
`define FLD_KIND_HI 20
`define FLD_KIND_LO 19
`define FLD_HDR_LO 16
`define FLD_DATA_HI 15

// Frame kinds
`define KIND_INPUT 2'h0
`define KIND_CLR_CODE 2'h1
`define KIND_CLR_EN 2'h2
`define KIND_OUTPUT 2'h3

// Packet check polynomial x^8 + x^2 + x + 1 and reset values
`define CHK_POLY 8'h07
`define CHK_INIT 8'h00
`define CODE_RESET 16'h0000

`endif

// ===== logic/pin_sync3.v
`timescale 1ns/100ps

// Three-stage pin synchroniser; the output moves only when stages two and three agree
module pin_sync3 (
  input wire ref_clk,
  input wire rst_n,
  input wire pin_in,
  input wire rst_val,
  output wire pin_out
);

  reg meta_ff;
  reg s2_ff;
  reg s3_ff;
  reg stable_ff;

  // First stage feeds only the second stage; all stages start at the pin's idle level
  // so that the release of reset cannot show a false edge downstream
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_ff <= rst_val;
      s2_ff <= rst_val;
      s3_ff <= rst_val;
    end else begin
      meta_ff <= pin_in;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
    end
  end

  // Agreement filter rejects a single-cycle disagreement
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      stable_ff <= rst_val;
    end else if (s2_ff == s3_ff) begin
      stable_ff <= s3_ff;
    end
  end

  assign pin_out = stable_ff;

endmodule // pin_sync3
